// file: hw/ccmc_mode_ctrl.sv
// Mode, routing and indicator control of a dual caption card
`timescale 1ns/1ps
`include "ccmc_defines.svh"

module ccmc_mode_ctrl #(
  parameter int TICK_CYC = `CCMC_TICK_CYC
) (
  // Clock and reset
  input  wire  logic                    pclk,
  input  wire  logic                    presetn,
  // APB slave
  input  wire  logic                    psel,
  input  wire  logic                    penable,
  input  wire  logic                    pwrite,
  input  wire  logic [11:0]             paddr,
  input  wire  logic [31:0]             pwdata,
  output logic       [31:0]             prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Rotary switches (pins)
  input  wire  logic [3:0]              comms_route_switch,
  input  wire  logic [3:0]              bridge_route_switch,
  // Host and video status (pins)
  input  wire  logic                    ser_data_seen,
  input  wire  logic                    net_data_seen,
  input  wire  logic [1:0]              video_locked,
  input  wire  logic [1:0]              video_is_hd,
  input  wire  logic [1:0]              video_fmt_ok,
  input  wire  logic [3:0]              contact_input_n,
  input  wire  logic [3:0]              vid_contact_bits,
  // Routing outputs
  output ccmc_pkg::ccmc_src_t           ins_src_a,
  output ccmc_pkg::ccmc_src_t           ins_src_b,
  output ccmc_pkg::ccmc_dec_t           dec_chan,
  output logic                          dec_to_ser,
  output logic                          dec_to_net,
  output logic                          cfg_ser,
  output logic                          cfg_net,
  output logic                          ser_ctrl_a,
  output logic                          ser_ctrl_b,
  output logic                          net_ctrl_a,
  output logic                          net_ctrl_b,
  // Bridge outputs
  output logic [1:0]                    bridge_ab_fld,
  output logic [1:0]                    bridge_ba_fld,
  output logic                          bridge_xcode,
  // Insert/regen per channel and field
  output logic [1:0]                    insert_a_fld,
  output logic [1:0]                    insert_b_fld,
  // Video outputs enables
  output logic [1:0]                    clean_out_en,
  output logic [1:0]                    burn_out_en,
  // Indicators and contacts
  output logic [1:0]                    led_input,
  output logic [3:0]                    led_contact_in,
  output logic [3:0]                    led_contact_out,
  output logic [3:0]                    contact_output
);
  import ccmc_pkg::*;

  if (TICK_CYC < 2 || TICK_CYC > 65535) begin
    $error("TICK_CYC out of range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  sw1_m;
    logic [3:0]  sw1_s;
    logic [3:0]  sw2_m;
    logic [3:0]  sw2_s;
    logic [3:0]  ci_m;
    logic [3:0]  ci_s;
    logic [1:0]  lk_m;
    logic [1:0]  lk_s;
    logic [1:0]  hd_m;
    logic [1:0]  hd_s;
    logic [1:0]  fo_m;
    logic [1:0]  fo_s;
    logic        ser_m;
    logic        ser_s;
    logic        net_m;
    logic        net_s;
    logic [3:0]  sw1_seen;
    logic [3:0]  sw2_seen;
    logic [7:0]  deb_cnt;
    logic        sw_valid;
    logic [3:0]  sw1_app;
    logic [3:0]  sw2_app;
    logic [15:0] div_cnt;
    logic        tick;
    logic [15:0] blink_cnt;
    logic        blink;
    logic [15:0] ser_idle;
    logic [15:0] net_idle;
    logic [15:0] timeout;
    logic [3:0]  fmode;
    logic [1:0]  out_en;
    logic [3:0]  contact_out;
    logic [31:0] rdata;
  } ccmc_state_t;

  ccmc_state_t s_q;
  ccmc_state_t s_d;

  logic        wr_acc;
  logic        rd_acc;
  logic        ser_alive;
  logic        net_alive;
  ccmc_src_t   src_a;
  ccmc_src_t   src_b;
  ccmc_dec_t   dec;
  logic        ins_on;
  logic [3:0]  sw2;
  logic        ab;
  logic        ba;
  logic [1:0]  fld;
  logic        ins_alive_a;
  logic        ins_alive_b;
  logic        addr_ok;

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & ~penable & ~pwrite;
  assign addr_ok = (paddr == `CCMC_OFF_SWITCH) || (paddr == `CCMC_OFF_ROUTE) ||
                   (paddr == `CCMC_OFF_MODE) || (paddr == `CCMC_OFF_TIMEOUT) ||
                   (paddr == `CCMC_OFF_STATUS) ||
                   (paddr == `CCMC_OFF_CONTACT) || (paddr == `CCMC_OFF_ID);

  // ----------------------------------------------------------------
  // Communications switch decode
  // ----------------------------------------------------------------
  always_comb begin
    src_a = CCMC_SRC_NONE;
    src_b = CCMC_SRC_NONE;
    dec   = CCMC_DEC_NONE;
    unique case (s_q.sw1_app)
      4'h0, 4'h3: begin
        src_a = CCMC_SRC_SER;
        src_b = CCMC_SRC_NET;
      end
      4'h1: begin
        src_a = CCMC_SRC_SER;
        src_b = CCMC_SRC_SER;
      end
      4'h2: begin
        src_a = CCMC_SRC_NET;
        src_b = CCMC_SRC_NET;
      end
      4'h4: begin
        src_a = CCMC_SRC_SER;
        src_b = CCMC_SRC_SER;
        dec   = CCMC_DEC_A;
      end
      4'h5: begin
        src_a = CCMC_SRC_NET;
        src_b = CCMC_SRC_NET;
        dec   = CCMC_DEC_B;
      end
      4'h6: begin
        src_a = CCMC_SRC_SER;
        src_b = CCMC_SRC_SER;
        dec   = CCMC_DEC_B;
      end
      4'h7: begin
        src_a = CCMC_SRC_NET;
        src_b = CCMC_SRC_NET;
        dec   = CCMC_DEC_A;
      end
      4'h8, 4'hB: dec = CCMC_DEC_A;
      4'h9, 4'hA: dec = CCMC_DEC_B;
      default: begin
        // C, D unused; E, F configuration only
        src_a = CCMC_SRC_NONE;
      end
    endcase
  end

  assign ins_src_a  = src_a;
  assign ins_src_b  = src_b;
  assign dec_chan   = dec;
  assign dec_to_ser = (dec != CCMC_DEC_NONE);
  assign dec_to_net = (dec != CCMC_DEC_NONE);
  assign cfg_ser    = (s_q.sw1_app == `CCMC_SW_CFG_SER);
  assign cfg_net    = (s_q.sw1_app == `CCMC_SW_CFG_NET);
  assign ser_ctrl_a = (src_a == CCMC_SRC_SER);
  assign ser_ctrl_b = (src_b == CCMC_SRC_SER);
  assign net_ctrl_a = (src_a == CCMC_SRC_NET);
  assign net_ctrl_b = (src_b == CCMC_SRC_NET);

  // ----------------------------------------------------------------
  // Bridge switch decode
  // ----------------------------------------------------------------
  assign sw2 = s_q.sw2_app;
  always_comb begin
    ab  = 1'b0;
    ba  = 1'b0;
    fld = 2'b00;
    unique case (sw2)
      4'h1: begin ab = 1'b1; fld = 2'b11; end
      4'h2: begin ba = 1'b1; fld = 2'b11; end
      4'h3: begin ab = 1'b1; fld = 2'b01; end
      4'h4: begin ba = 1'b1; fld = 2'b01; end
      4'h5: begin ab = 1'b1; fld = 2'b10; end
      4'h6: begin ba = 1'b1; fld = 2'b10; end
      default: fld = 2'b00;
    endcase
  end

  assign bridge_ab_fld = ab ? fld : 2'b00;
  assign bridge_ba_fld = ba ? fld : 2'b00;
  assign bridge_xcode  = (ab | ba) &
                         (s_q.hd_s[0] != s_q.hd_s[1]);

  // ----------------------------------------------------------------
  // Insert / regen per field
  // ----------------------------------------------------------------
  assign ser_alive = (s_q.ser_idle < s_q.timeout);
  assign net_alive = (s_q.net_idle < s_q.timeout);
  assign ins_alive_a = (src_a == CCMC_SRC_SER) ? ser_alive :
                       (src_a == CCMC_SRC_NET) ? net_alive : 1'b0;
  assign ins_alive_b = (src_b == CCMC_SRC_SER) ? ser_alive :
                       (src_b == CCMC_SRC_NET) ? net_alive : 1'b0;
  assign ins_on = (src_a != CCMC_SRC_NONE);

  function automatic logic fld_ins(input logic [1:0] m, input logic alive,
                                   input logic en);
    logic r;
    r = 1'b0;
    unique case (ccmc_fmode_t'(m))
      CCMC_FM_INSERT: r = en;
      CCMC_FM_REGEN:  r = 1'b0;
      default:        r = en & alive;
    endcase
    return r;
  endfunction

  assign insert_a_fld = {
    fld_ins(s_q.fmode[`CCMC_MODE_F2], ins_alive_a, ins_on),
    fld_ins(s_q.fmode[`CCMC_MODE_F1], ins_alive_a, ins_on)};
  assign insert_b_fld = {
    fld_ins(s_q.fmode[`CCMC_MODE_F2], ins_alive_b, ins_on),
    fld_ins(s_q.fmode[`CCMC_MODE_F1], ins_alive_b, ins_on)};

  // ----------------------------------------------------------------
  // Outputs and indicators
  // ----------------------------------------------------------------
  assign clean_out_en = s_q.out_en & s_q.fo_s;
  assign burn_out_en  = s_q.out_en & s_q.fo_s;
  assign led_input    = s_q.lk_s | {2{s_q.blink}};
  assign led_contact_in  = ~s_q.ci_s;
  assign led_contact_out = s_q.contact_out;
  assign contact_output  = s_q.contact_out;
  assign prdata  = s_q.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Pin synchronisers
    s_d.sw1_m = comms_route_switch;
    s_d.sw1_s = s_q.sw1_m;
    s_d.sw2_m = bridge_route_switch;
    s_d.sw2_s = s_q.sw2_m;
    s_d.ci_m  = contact_input_n;
    s_d.ci_s  = s_q.ci_m;
    s_d.lk_m  = video_locked;
    s_d.lk_s  = s_q.lk_m;
    s_d.hd_m  = video_is_hd;
    s_d.hd_s  = s_q.hd_m;
    s_d.fo_m  = video_fmt_ok;
    s_d.fo_s  = s_q.fo_m;
    s_d.ser_m = ser_data_seen;
    s_d.ser_s = s_q.ser_m;
    s_d.net_m = net_data_seen;
    s_d.net_s = s_q.net_m;

    // Millisecond tick
    s_d.tick = 1'b0;
    if (s_q.div_cnt == 16'(TICK_CYC - 1)) begin
      s_d.div_cnt = 16'h0000;
      s_d.tick    = 1'b1;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 16'h0001;
    end

    // 1 Hz blink
    if (s_q.tick) begin
      if (s_q.blink_cnt == `CCMC_BLINK_HALF - 16'd1) begin
        s_d.blink_cnt = 16'h0000;
        s_d.blink     = ~s_q.blink;
      end else begin
        s_d.blink_cnt = s_q.blink_cnt + 16'h0001;
      end
    end

    // Switch settle filter
    if (s_q.sw1_s != s_q.sw1_seen || s_q.sw2_s != s_q.sw2_seen) begin
      s_d.sw1_seen = s_q.sw1_s;
      s_d.sw2_seen = s_q.sw2_s;
      s_d.deb_cnt  = 8'h00;
    end else if (s_q.tick && s_q.deb_cnt != `CCMC_DEB_MS) begin
      s_d.deb_cnt = s_q.deb_cnt + 8'h01;
    end else if (s_q.deb_cnt == `CCMC_DEB_MS) begin
      s_d.sw1_app  = s_q.sw1_seen;
      s_d.sw2_app  = s_q.sw2_seen;
      s_d.sw_valid = 1'b1;
    end

    // Host idle timers in ms
    if (s_q.ser_s) begin
      s_d.ser_idle = 16'h0000;
    end else if (s_q.tick && s_q.ser_idle != `CCMC_IDLE_MAX) begin
      s_d.ser_idle = s_q.ser_idle + 16'h0001;
    end
    if (s_q.net_s) begin
      s_d.net_idle = 16'h0000;
    end else if (s_q.tick && s_q.net_idle != `CCMC_IDLE_MAX) begin
      s_d.net_idle = s_q.net_idle + 16'h0001;
    end

    // Contact outputs from video
    s_d.contact_out = vid_contact_bits;

    // Register writes
    if (wr_acc) begin
      unique case (paddr)
        `CCMC_OFF_MODE:    s_d.fmode   = pwdata[3:0];
        `CCMC_OFF_TIMEOUT: s_d.timeout = pwdata[15:0];
        `CCMC_OFF_ROUTE:   s_d.out_en  = pwdata[1:0];
        default:           s_d.fmode   = s_d.fmode;
      endcase
    end

    // Read data captured in setup phase
    if (rd_acc) begin
      unique case (paddr)
        `CCMC_OFF_SWITCH:  s_d.rdata = {19'h0, s_q.sw_valid,
                                        s_q.sw2_app, 4'h0, s_q.sw1_app};
        `CCMC_OFF_ROUTE:   s_d.rdata = {22'h0, 2'(dec), 2'(src_b),
                                        2'(src_a), 2'h0, s_q.out_en};
        `CCMC_OFF_MODE:    s_d.rdata = {24'h0, insert_b_fld, insert_a_fld,
                                        s_q.fmode};
        `CCMC_OFF_TIMEOUT: s_d.rdata = {16'h0, s_q.timeout};
        `CCMC_OFF_STATUS:  s_d.rdata = {24'h0, s_q.hd_s, s_q.fo_s,
                                        s_q.lk_s, net_alive, ser_alive};
        `CCMC_OFF_CONTACT: s_d.rdata = {24'h0, s_q.contact_out,
                                        ~s_q.ci_s};
        `CCMC_OFF_ID:      s_d.rdata = `CCMC_ID_RST;
        default:           s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q         <= '0;
      s_q.ci_m    <= `CCMC_CI_IDLE;
      s_q.ci_s    <= `CCMC_CI_IDLE;
      s_q.timeout <= `CCMC_TIMEOUT_RST;
      s_q.fmode   <= `CCMC_MODE_RST;
      s_q.out_en  <= `CCMC_OUTEN_RST;
      s_q.sw1_app <= `CCMC_SW_NOFUNC;
      s_q.sw2_app <= 4'h0;
      s_q.ser_idle <= `CCMC_IDLE_MAX;
      s_q.net_idle <= `CCMC_IDLE_MAX;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// file: pkg/ccmc_defines.svh
// Constants for the caption card mode control block
`ifndef CCMC_DEFINES_SVH
`define CCMC_DEFINES_SVH

// Register byte offsets
`define CCMC_OFF_SWITCH   12'h000
`define CCMC_OFF_ROUTE    12'h004
`define CCMC_OFF_MODE     12'h008
`define CCMC_OFF_TIMEOUT  12'h00C
`define CCMC_OFF_STATUS   12'h010
`define CCMC_OFF_CONTACT  12'h014
`define CCMC_OFF_ID       12'h018

// Reset values
`define CCMC_TIMEOUT_RST  16'h0032
`define CCMC_MODE_RST     4'h0
`define CCMC_ID_RST       32'h0000_5A01
// Applied switch before the first settled reading: no function
`define CCMC_SW_NOFUNC    4'hC
`define CCMC_OUTEN_RST    2'b11
// Contact inputs idle high (active low)
`define CCMC_CI_IDLE      4'hF
// Host idle timer saturation
`define CCMC_IDLE_MAX     16'hFFFF

// Timing: 10 MHz clock, 1 ms tick
`define CCMC_CLK_HZ       10000000
`define CCMC_TICK_HZ      1000
`define CCMC_TICK_CYC     (`CCMC_CLK_HZ / `CCMC_TICK_HZ)
// Blink half period in ms for 1 Hz
`define CCMC_BLINK_HALF   16'd500
// Switch settle time in ms
`define CCMC_DEB_MS       8'd20

// Switch codes
`define CCMC_SW_CFG_SER   4'hE
`define CCMC_SW_CFG_NET   4'hF

// Mode field positions in the mode register
`define CCMC_MODE_F1      1:0
`define CCMC_MODE_F2      3:2

`endif

// file: pkg/ccmc_pkg.sv
// Types for the caption card mode control block
package ccmc_pkg;

  typedef enum logic [1:0] {
    CCMC_SRC_NONE,
    CCMC_SRC_SER,
    CCMC_SRC_NET
  } ccmc_src_t;

  typedef enum logic [1:0] {
    CCMC_FM_AUTO,
    CCMC_FM_INSERT,
    CCMC_FM_REGEN,
    CCMC_FM_RSVD
  } ccmc_fmode_t;

  typedef enum logic [1:0] {
    CCMC_DEC_NONE,
    CCMC_DEC_A,
    CCMC_DEC_B
  } ccmc_dec_t;

endpackage

// file: verif/ccmc_host_model.sv
// Caption workstation model driving host data activity
`timescale 1ns/1ps
module ccmc_host_model (
  // Clock
  input  wire logic pclk,
  // Traffic enables from the bench
  input  wire logic run_ser,
  input  wire logic run_net,
  // Activity seen by the card
  output logic      ser_data_seen,
  output logic      net_data_seen
);
  logic [2:0] cnt_q = 3'h0;
  // One caption word every eight cycles per active port
  always_ff @(posedge pclk) begin
    cnt_q <= cnt_q + 3'h1;
  end
  assign ser_data_seen = run_ser && (cnt_q == 3'h0);
  assign net_data_seen = run_net && (cnt_q == 3'h5);
endmodule

// file: verif/ccmc_mode_ctrl_properties.sv
// Concurrent checks on the mode control block ports
`timescale 1ns/1ps
module ccmc_mode_ctrl_props #(
  parameter int TICK_CYC = 4
) (
  // Clock and reset
  input wire logic             pclk,
  input wire logic             presetn,
  // Pins
  input wire logic [3:0]       comms_route_switch,
  input wire logic [1:0]       video_locked,
  input wire logic [3:0]       contact_input_n,
  input wire logic [3:0]       vid_contact_bits,
  // Outputs watched
  input ccmc_pkg::ccmc_src_t   ins_src_a,
  input ccmc_pkg::ccmc_dec_t   dec_chan,
  input wire logic             dec_to_ser,
  input wire logic             dec_to_net,
  input wire logic             cfg_ser,
  input wire logic             cfg_net,
  input wire logic [1:0]       bridge_ab_fld,
  input wire logic [1:0]       bridge_ba_fld,
  input wire logic [1:0]       insert_a_fld,
  input wire logic [1:0]       led_input,
  input wire logic [3:0]       led_contact_in,
  input wire logic [3:0]       led_contact_out,
  input wire logic [3:0]       contact_output
);
  import ccmc_pkg::*;
  localparam int SETTLE = 19 * TICK_CYC;
  logic [3:0] sw_last_q;
  int         sw_age_q;
  // Cycles since the comms switch pins last moved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_last_q <= 4'h0;
      sw_age_q  <= 0;
    end else begin
      sw_last_q <= comms_route_switch;
      if (comms_route_switch != sw_last_q)
        sw_age_q <= 0;
      else if (sw_age_q < SETTLE)
        sw_age_q <= sw_age_q + 1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence in_steady;
    $stable(contact_input_n)[*5];
  endsequence
  sequence locked_a;
    video_locked[0][*5];
  endsequence
  sequence no_src_a;
    (ins_src_a == CCMC_SRC_NONE)[*3];
  endsequence
  AST_DEC_BOTH: assert property (
    dec_chan != CCMC_DEC_NONE |-> dec_to_ser && dec_to_net)
    else $error("decode not sent to both hosts");
  AST_NO_DEC: assert property (
    dec_chan == CCMC_DEC_NONE |-> !dec_to_ser && !dec_to_net)
    else $error("decode output without decode channel");
  AST_CFG_ONE: assert property (!(cfg_ser && cfg_net))
    else $error("configuration given to both ports");
  AST_CFG_QUIET: assert property (
    cfg_ser || cfg_net |-> ins_src_a == CCMC_SRC_NONE
      && dec_chan == CCMC_DEC_NONE)
    else $error("configuration setting routes captions");
  AST_NOSRC_NOINS: assert property (
    no_src_a |-> insert_a_fld == 2'b00)
    else $error("insert without a source");
  AST_BRIDGE_ONEWAY: assert property (
    (bridge_ab_fld & bridge_ba_fld) == 2'b00)
    else $error("bridge both ways on one field");
  AST_GPO: assert property (
    $past(presetn) |-> contact_output == $past(vid_contact_bits))
    else $error("contact output not following video bits");
  AST_GPO_LED: assert property (
    led_contact_out == contact_output)
    else $error("contact output indicator wrong");
  AST_GPI_LED: assert property (
    in_steady |-> led_contact_in == ~contact_input_n)
    else $error("contact input indicator wrong");
  AST_LOCK_LED: assert property (locked_a |-> led_input[0])
    else $error("input indicator dark while locked");
  AST_SW_SETTLE: assert property (
    $changed(ins_src_a) |-> sw_age_q >= SETTLE)
    else $error("route changed before switch settled");
endmodule
bind ccmc_mode_ctrl ccmc_mode_ctrl_props #(.TICK_CYC(TICK_CYC)) props_i (
  .pclk(pclk), .presetn(presetn), .comms_route_switch(comms_route_switch),
  .video_locked(video_locked), .contact_input_n(contact_input_n),
  .vid_contact_bits(vid_contact_bits), .ins_src_a(ins_src_a),
  .dec_chan(dec_chan), .dec_to_ser(dec_to_ser), .dec_to_net(dec_to_net),
  .cfg_ser(cfg_ser), .cfg_net(cfg_net), .bridge_ab_fld(bridge_ab_fld),
  .bridge_ba_fld(bridge_ba_fld), .insert_a_fld(insert_a_fld),
  .led_input(led_input), .led_contact_in(led_contact_in),
  .led_contact_out(led_contact_out), .contact_output(contact_output));

// file: verif/ccmc_mode_ctrl_tb.sv
// Self-checking testbench of the mode control block
`timescale 1ns/1ps
`include "ccmc_defines.svh"
module ccmc_mode_ctrl_tb;
  import ccmc_pkg::*;
  localparam int TC = 4;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  sw1, sw2, cin_n, vbits, led_ci, led_co, cout;
  logic [1:0]  lock, hd, fmt, ab, ba, ins_a, ins_b, led_in, eab, eba;
  logic        sds, nds, run_ser, run_net, d_ser, d_net, c_ser, c_net;
  logic        xc, serr, v, sa, sb, na, nb;
  logic [1:0]  cln, brn;
  ccmc_src_t   src_a, src_b, ea, eb;
  ccmc_dec_t   dec, ed;
  int          n_errors, tests_run, k;
  ccmc_mode_ctrl #(.TICK_CYC(TC)) ccmc_mode_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comms_route_switch(sw1),
    .bridge_route_switch(sw2), .ser_data_seen(sds), .net_data_seen(nds),
    .video_locked(lock), .video_is_hd(hd), .video_fmt_ok(fmt),
    .contact_input_n(cin_n), .vid_contact_bits(vbits),
    .ins_src_a(src_a), .ins_src_b(src_b), .dec_chan(dec),
    .dec_to_ser(d_ser), .dec_to_net(d_net), .cfg_ser(c_ser),
    .cfg_net(c_net), .ser_ctrl_a(sa), .ser_ctrl_b(sb), .net_ctrl_a(na),
    .net_ctrl_b(nb), .bridge_ab_fld(ab), .bridge_ba_fld(ba),
    .bridge_xcode(xc), .insert_a_fld(ins_a), .insert_b_fld(ins_b),
    .clean_out_en(cln), .burn_out_en(brn), .led_input(led_in),
    .led_contact_in(led_ci), .led_contact_out(led_co),
    .contact_output(cout));
  ccmc_host_model ccmc_host_model_i (.pclk(pclk), .run_ser(run_ser),
    .run_net(run_net), .ser_data_seen(sds), .net_data_seen(nds));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic tmo(input string m);
    n_errors++;
    $display("mismatch at %0t: %s timed out", $time, m);
    summarize();
  endtask
  // APB transfer: setup, access until pready, then release
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) tmo("apb");
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Turn both switches and wait until the new setting is applied
  task automatic setsw(input logic [3:0] a, b);
    int n;
    sw1 <= a;
    sw2 <= b;
    for (n = 0; n < 40; n++) begin
      repeat (10) @(posedge pclk);
      apb(1'b0, `CCMC_OFF_SWITCH, 32'h0);
      if (rd[12] === 1'b1 && rd[11:8] === b && rd[3:0] === a) break;
    end
    if (n >= 40) tmo("switch settle");
    repeat (4) @(posedge pclk);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    sw1 = 4'h0;
    sw2 = 4'h0;
    cin_n = 4'hF;
    vbits = 4'h0;
    lock = 2'b00;
    hd = 2'b00;
    fmt = 2'b00;
    run_ser = 1'b0;
    run_net = 1'b0;
    n_errors = 0;
    tests_run = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `CCMC_OFF_TIMEOUT, 32'h0);
    chk(rd, `CCMC_TIMEOUT_RST, "timeout reset");
    apb(1'b1, `CCMC_OFF_ID, 32'hFFFF_FFFF);
    apb(1'b0, `CCMC_OFF_ID, 32'h0);
    chk(rd, `CCMC_ID_RST, "id read only");
    apb(1'b0, 12'h100, 32'h0);
    chk(serr, 1'b1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    $display("test registers done");
    fmt <= 2'b11;
    hd <= 2'b01;
    for (int i = 0; i < 16; i++) begin
      setsw(i[3:0], i[3:0]);
      ea = (i > 7) ? CCMC_SRC_NONE
         : (i inside {2, 5, 7}) ? CCMC_SRC_NET : CCMC_SRC_SER;
      eb = (i > 7) ? CCMC_SRC_NONE
         : (i inside {1, 4, 6}) ? CCMC_SRC_SER : CCMC_SRC_NET;
      ed = (i inside {4, 7, 8, 11}) ? CCMC_DEC_A
         : (i inside {5, 6, 9, 10}) ? CCMC_DEC_B : CCMC_DEC_NONE;
      eab = (i == 1) ? 2'b11 : (i == 3) ? 2'b01 : (i == 5) ? 2'b10 : 2'b00;
      eba = (i == 2) ? 2'b11 : (i == 4) ? 2'b01 : (i == 6) ? 2'b10 : 2'b00;
      chk(src_a, ea, "source a");
      chk(src_b, eb, "source b");
      chk(dec, ed, "decode channel");
      chk({sa, na, sb, nb}, {ea == CCMC_SRC_SER, ea == CCMC_SRC_NET,
           eb == CCMC_SRC_SER, eb == CCMC_SRC_NET}, "host control");
      chk({d_ser, d_net}, {2{ed != CCMC_DEC_NONE}}, "decode out");
      chk({c_ser, c_net}, {i == 14, i == 15}, "config port");
      chk({ab, ba}, {eab, eba}, "bridge fields");
      chk(xc, (eab | eba) != 2'b00, "transcode");
      if (i == 1) begin
        hd <= 2'b11;
        repeat (4) @(posedge pclk);
        chk(xc, 1'b0, "same format no transcode");
        hd <= 2'b01;
      end
    end
    $display("test routing done");
    setsw(4'h0, 4'h0);
    apb(1'b0, `CCMC_OFF_ROUTE, 32'h0);
    chk(rd, 32'h0000_0093, "route readback");
    chk({cln, brn}, 4'hF, "outputs on");
    fmt <= 2'b10;
    apb(1'b1, `CCMC_OFF_ROUTE, 32'h1);
    repeat (4) @(posedge pclk);
    chk({cln, brn}, 4'h0, "outputs gated");
    fmt <= 2'b11;
    apb(1'b1, `CCMC_OFF_ROUTE, 32'h3);
    apb(1'b1, `CCMC_OFF_TIMEOUT, 32'h5);
    apb(1'b1, `CCMC_OFF_MODE, 32'h0);
    run_ser <= 1'b1;
    repeat (60) @(posedge pclk);
    chk(ins_a, 2'b11, "auto insert");
    chk(ins_b, 2'b00, "idle port regen");
    run_ser <= 1'b0;
    repeat (60) @(posedge pclk);
    chk(ins_a, 2'b00, "back to regen");
    apb(1'b1, `CCMC_OFF_MODE, 32'h9);
    repeat (4) @(posedge pclk);
    chk({ins_a, ins_b}, 4'h5, "forced 9");
    apb(1'b1, `CCMC_OFF_MODE, 32'h6);
    repeat (4) @(posedge pclk);
    chk({ins_a, ins_b}, 4'hA, "forced 6");
    apb(1'b0, `CCMC_OFF_MODE, 32'h0);
    chk(rd[3:0], 4'h6, "mode readback");
    apb(1'b1, `CCMC_OFF_MODE, 32'h0);
    apb(1'b1, `CCMC_OFF_TIMEOUT, 32'h0);
    run_ser <= 1'b1;
    repeat (60) @(posedge pclk);
    chk(ins_a, 2'b00, "zero timeout");
    run_ser <= 1'b0;
    $display("test insert mode done");
    vbits <= 4'hA;
    cin_n <= 4'h6;
    repeat (8) @(posedge pclk);
    chk(cout, 4'hA, "contact out");
    chk({led_co, led_ci}, 8'hA9, "contact leds");
    apb(1'b0, `CCMC_OFF_CONTACT, 32'h0);
    chk(rd[7:0], 8'hA9, "contact status");
    $display("test contacts done");
    lock <= 2'b01;
    repeat (8) @(posedge pclk);
    chk(led_in[0], 1'b1, "locked led");
    apb(1'b0, `CCMC_OFF_STATUS, 32'h0);
    chk(rd, 32'h0000_0074, "status word");
    v = led_in[1];
    for (k = 0; k < 2100 && led_in[1] === v; k++) @(posedge pclk);
    if (k >= 2100) tmo("blink start");
    v = led_in[1];
    for (k = 0; k < 2100 && led_in[1] === v; k++) @(posedge pclk);
    if (k >= 2100) tmo("blink half period");
    chk(k >= 1990 && k <= 2010, 1'b1, "blink half period");
    $display("test indicators done");
    summarize();
  end
endmodule
